// >>> hdl/sff_regs.svh
// Register offsets, field positions, reset values and counts of the setup filter
`ifndef SFF_REGS_SVH
`define SFF_REGS_SVH
`define SFF_STATUS_OFS 8'h14
`define SFF_OPMODE_OFS 8'h18
`define SFF_STATUS_RESET 32'h0000_0000
`define SFF_OPMODE_RESET 32'h0000_0000
`define SFF_ST_TX_DONE 1
`define SFF_OM_PROMISC 1
`define SFF_OM_ALLMULTI 2
`define SFF_OM_INT_EN 30
`define SFF_W0_BAD_LEN 13
`define SFF_W0_ERR_SUM 15
`define SFF_W0_HOLDER 31
`define SFF_W1_NOTIFY 24
`define SFF_W1_HASH 25
`define SFF_W1_INVERT 26
`define SFF_W1_KIND_HI 29
`define SFF_W1_KIND_LO 28
`define SFF_W2_LEN_HI 30
`define SFF_W2_LEN_LO 16
`define SFF_W3_PTR_HI 29
`define SFF_W3_PTR_LO 1
`define SFF_KIND_SETUP 2'h2
`define SFF_SETUP_BYTES 15'h0080
`define SFF_SETUP_WORDS 6'h20
`define SFF_HASH_WORDS 5'h10
`define SFF_CRC_INIT 32'hFFFF_FFFF
`define SFF_CRC_POLY 32'hEDB8_8320
`endif

// >>> hdl/sff_pkg.sv
// Types shared by the setup filter
package sff_pkg;
    typedef enum logic [2:0] {
        SFF_IDLE,
        SFF_PEND,
        SFF_CHECK,
        SFF_FETCH,
        SFF_WRBACK
    } sff_state_e;
endpackage

// >>> hdl/sff_filter.sv
// Setup frame loader and destination address filter
// Notes on behaviour
// - setup frame consumed internally, never sent
// - receiver detached while setup frame processed
// - wrong length sets bits 13 and 15
// - cleared table passes only all-zero address
// - process when tx runs, queue drained, rx idle
// - reception state untouched by setup processing
// - clear holder bit 31 when finished
// - notify bit 24 sets status bit 01
// - bit 25 selects hash or perfect filtering
// - bit 26 inverts perfect match, modes off
// - sixteen 48-bit addresses compared each frame
// - lowest bit of first byte means multicast
// - hash table plus one physical address
// - CRC low nine bits index table
// - index selects longword idx/32, bit idx%32
// - status raises interrupt only if enabled
//
// Implementation choices: the address map and strobed register access.
`timescale 1ns/1ps
`default_nettype none
`include "sff_regs.svh"
module sff_filter #(
    parameter int ADDR_W = 8
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Register port
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    output logic irq,
    // Setup descriptor from transmit engine
    input wire logic setup_req,
    input wire logic [31:0] cfg_desc_word1,
    input wire logic [31:0] cfg_desc_word2,
    input wire logic [31:0] cfg_desc_word3,
    input wire logic tx_running,
    input wire logic tx_quiet,
    input wire logic rx_busy,
    output logic setup_busy,
    output logic rx_detach,
    // Buffer read over DMA
    output logic dma_rd_req,
    output logic [31:0] dma_rd_addr,
    input wire logic dma_rd_ack,
    input wire logic [31:0] dma_rd_data,
    // Descriptor word 0 write-back
    output logic desc_wr_valid,
    output logic [31:0] cfg_desc_word0,
    // Destination address check
    input wire logic da_valid,
    input wire logic [47:0] da,
    output logic filt_valid,
    output logic filt_accept
);
    sff_pkg::sff_state_e state;
    logic [31:0] filt_mem [0:31];
    logic [31:0] status_reg;
    logic [31:0] operating_mode_reg;
    logic [31:0] w1;
    logic [31:0] w2;
    logic [31:0] w3;
    logic [5:0] word_cnt;
    logic bad_length_flag;
    logic hash_mode_select;
    logic invert;
    logic next_match;
    logic next_accept;
    logic [31:0] hash_crc;
    logic [8:0] hash_idx;
    logic [47:0] phys_addr;
    logic is_multicast;

    // Reflected Ethernet CRC over six address bytes, first byte lowest
    function automatic logic [31:0] sff_crc48(input logic [47:0] d);
        logic [31:0] c;
        c = `SFF_CRC_INIT;
        for (int i = 0; i < 48; i++) begin
            if (c[0] ^ d[i]) begin
                c = (c >> 1) ^ `SFF_CRC_POLY;
            end else begin
                c = c >> 1;
            end
        end
        return c;
    endfunction

    // Two longwords to a 48-bit address
    function automatic logic [47:0] sff_addr(input logic [31:0] lo, input logic [31:0] hi);
        return {hi[15:0], lo};
    endfunction

    // Setup sequencer
    always_ff @(posedge clk) begin
        if (reset) begin
            state <= sff_pkg::SFF_IDLE;
            w1 <= 32'h0000_0000;
            w2 <= 32'h0000_0000;
            w3 <= 32'h0000_0000;
            word_cnt <= 6'h00;
            bad_length_flag <= 1'b0;
        end else begin
            case (state)
                sff_pkg::SFF_IDLE: begin
                    // Accepted in any reception state
                    if (setup_req) begin
                        w1 <= cfg_desc_word1;
                        w2 <= cfg_desc_word2;
                        w3 <= cfg_desc_word3;
                        state <= sff_pkg::SFF_PEND;
                    end
                end
                sff_pkg::SFF_PEND: begin
                    if (tx_running && tx_quiet && !rx_busy) begin
                        state <= sff_pkg::SFF_CHECK;
                    end
                end
                sff_pkg::SFF_CHECK: begin
                    word_cnt <= 6'h00;
                    bad_length_flag <= w2[`SFF_W2_LEN_HI:`SFF_W2_LEN_LO] != `SFF_SETUP_BYTES;
                    if (w2[`SFF_W2_LEN_HI:`SFF_W2_LEN_LO] != `SFF_SETUP_BYTES) begin
                        state <= sff_pkg::SFF_WRBACK;
                    end else begin
                        state <= sff_pkg::SFF_FETCH;
                    end
                end
                sff_pkg::SFF_FETCH: begin
                    if (dma_rd_ack) begin
                        word_cnt <= word_cnt + 6'h01;
                        if (word_cnt == `SFF_SETUP_WORDS - 6'h01) begin
                            state <= sff_pkg::SFF_WRBACK;
                        end
                    end
                end
                sff_pkg::SFF_WRBACK: begin
                    state <= sff_pkg::SFF_IDLE;
                end
                default: begin
                    state <= sff_pkg::SFF_IDLE;
                end
            endcase
        end
    end

    // Buffer words land in the table only; never passed on
    always_ff @(posedge clk) begin
        if (reset) begin
            for (int i = 0; i < 32; i++) begin
                filt_mem[i] <= 32'h0000_0000;
            end
        end else if (state == sff_pkg::SFF_FETCH && dma_rd_ack) begin
            filt_mem[word_cnt[4:0]] <= dma_rd_data;
        end
    end

    // Filter mode taken from a loaded setup frame
    always_ff @(posedge clk) begin
        if (reset) begin
            hash_mode_select <= 1'b0;
            invert <= 1'b0;
        end else if (state == sff_pkg::SFF_WRBACK && !bad_length_flag) begin
            hash_mode_select <= w1[`SFF_W1_HASH];
            invert <= w1[`SFF_W1_INVERT];
        end
    end

    assign setup_busy = state != sff_pkg::SFF_IDLE;
    // Detach only; reception state machine is left alone
    assign rx_detach = state == sff_pkg::SFF_CHECK || state == sff_pkg::SFF_FETCH
        || state == sff_pkg::SFF_WRBACK;
    assign dma_rd_req = state == sff_pkg::SFF_FETCH;
    assign dma_rd_addr = {2'b00, w3[`SFF_W3_PTR_HI:`SFF_W3_PTR_LO], 1'b0}
        + {24'h0000_00, word_cnt, 2'b00};
    assign desc_wr_valid = state == sff_pkg::SFF_WRBACK;
    // Holder cleared, error bits as found
    always_comb begin
        cfg_desc_word0 = 32'h0000_0000;
        cfg_desc_word0[`SFF_W0_BAD_LEN] = bad_length_flag;
        cfg_desc_word0[`SFF_W0_ERR_SUM] = bad_length_flag;
    end

    // Status and operating mode registers
    always_ff @(posedge clk) begin
        if (reset) begin
            status_reg <= `SFF_STATUS_RESET;
        end else begin
            if (reg_wr && reg_addr == `SFF_STATUS_OFS) begin
                status_reg[`SFF_ST_TX_DONE] <= status_reg[`SFF_ST_TX_DONE]
                    & ~reg_wdata[`SFF_ST_TX_DONE];
            end
            // Set wins over write-one clear
            if (state == sff_pkg::SFF_WRBACK && w1[`SFF_W1_NOTIFY]) begin
                status_reg[`SFF_ST_TX_DONE] <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            operating_mode_reg <= `SFF_OPMODE_RESET;
        end else if (reg_wr && reg_addr == `SFF_OPMODE_OFS) begin
            operating_mode_reg <= reg_wdata;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            reg_rdata <= 32'h0000_0000;
        end else if (reg_rd) begin
            if (reg_addr == `SFF_STATUS_OFS) begin
                reg_rdata <= status_reg;
            end else if (reg_addr == `SFF_OPMODE_OFS) begin
                reg_rdata <= operating_mode_reg;
            end else begin
                reg_rdata <= 32'h0000_0000;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            irq <= 1'b0;
        end else begin
            irq <= status_reg[`SFF_ST_TX_DONE] & operating_mode_reg[`SFF_OM_INT_EN];
        end
    end

    // Address match
    assign is_multicast = da[0];
    assign hash_crc = sff_crc48(da);
    assign hash_idx = hash_crc[8:0];
    assign phys_addr = sff_addr(filt_mem[`SFF_HASH_WORDS], filt_mem[`SFF_HASH_WORDS + 5'h01]);

    always_comb begin
        next_match = 1'b0;
        for (int i = 0; i < 16; i++) begin
            if (sff_addr(filt_mem[2*i], filt_mem[2*i+1]) == da) begin
                next_match = 1'b1;
            end
        end
    end

    always_comb begin
        if (operating_mode_reg[`SFF_OM_PROMISC]) begin
            next_accept = 1'b1;
        end else if (operating_mode_reg[`SFF_OM_ALLMULTI] && is_multicast) begin
            next_accept = 1'b1;
        end else if (hash_mode_select) begin
            if (is_multicast) begin
                next_accept = filt_mem[{1'b0, hash_idx[8:5]}][hash_idx[4:0]];
            end else begin
                next_accept = da == phys_addr;
            end
        end else if (!operating_mode_reg[`SFF_OM_ALLMULTI] && invert) begin
            next_accept = !next_match;
        end else begin
            next_accept = next_match;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            filt_valid <= 1'b0;
            filt_accept <= 1'b0;
        end else begin
            filt_valid <= da_valid && !rx_detach;
            if (da_valid) begin
                filt_accept <= next_accept;
            end
        end
    end

    // Checks
    sequence load_seq;
        state == sff_pkg::SFF_CHECK ##1 state == sff_pkg::SFF_FETCH;
    endsequence

    detach_busy_a: assert property (@(posedge clk) disable iff (reset)
        desc_wr_valid |-> rx_detach && $past(rx_detach))
        else $error("receiver not detached during setup");

    start_gate_a: assert property (@(posedge clk) disable iff (reset)
        state == sff_pkg::SFF_CHECK |-> $past(tx_running && tx_quiet && !rx_busy))
        else $error("setup started while not allowed");

    bad_length_a: assert property (@(posedge clk) disable iff (reset)
        state == sff_pkg::SFF_CHECK && w2[30:16] != 15'h0080 |=> desc_wr_valid
        && cfg_desc_word0[13] && cfg_desc_word0[15])
        else $error("length error not reported");

    holder_clear_a: assert property (@(posedge clk) disable iff (reset)
        desc_wr_valid |-> !cfg_desc_word0[31] ##1 state == sff_pkg::SFF_IDLE)
        else $error("holder bit not returned");

    notify_set_a: assert property (@(posedge clk) disable iff (reset)
        desc_wr_valid && w1[24] |=> status_reg[1])
        else $error("transmit done not set");

    irq_gate_a: assert property (@(posedge clk) disable iff (reset)
        irq |-> $past(operating_mode_reg[30] && status_reg[1]))
        else $error("interrupt without enable");

    fetch_start_a: assert property (@(posedge clk) disable iff (reset)
        load_seq |-> dma_rd_req && rx_detach)
        else $error("buffer fetch not started while detached");

    fetch_len_a: assert property (@(posedge clk) disable iff (reset)
        desc_wr_valid && !bad_length_flag |-> word_cnt == `SFF_SETUP_WORDS)
        else $error("write-back before whole buffer fetched");

    detach_drop_a: assert property (@(posedge clk) disable iff (reset)
        da_valid && rx_detach |=> !filt_valid)
        else $error("frame taken while detached");

    pend_wait_a: assert property (@(posedge clk) disable iff (reset)
        state == sff_pkg::SFF_PEND && !(tx_running && tx_quiet && !rx_busy)
        |=> state == sff_pkg::SFF_PEND)
        else $error("setup left wait state too early");

    invert_only_a: assert property (@(posedge clk) disable iff (reset)
        da_valid && !hash_mode_select && invert && operating_mode_reg[2:1] == 2'b00
        |=> filt_accept == !$past(next_match))
        else $error("inverse match not applied");

    phys_hash_a: assert property (@(posedge clk) disable iff (reset)
        da_valid && hash_mode_select && !da[0] && operating_mode_reg[2:1] == 2'b00
        |=> filt_accept == $past(da == phys_addr))
        else $error("physical address not matched against stored one");

    promisc_a: assert property (@(posedge clk) disable iff (reset)
        da_valid && operating_mode_reg[1] |=> filt_accept)
        else $error("promiscuous frame rejected");

    mode_hold_a: assert property (@(posedge clk) disable iff (reset)
        state == sff_pkg::SFF_WRBACK && !bad_length_flag |=> hash_mode_select == $past(w1[25]))
        else $error("filter mode not loaded");
endmodule
`default_nettype wire

// >>> sim/sff_host_mem.sv
// Host memory model answering setup buffer reads
`timescale 1ns/1ps
`default_nettype none
module sff_host_mem (
    // Clock
    input wire logic clk,
    // Buffer read port
    input wire logic rd_req,
    input wire logic [31:0] rd_addr,
    output logic rd_ack,
    output logic [31:0] rd_data
);
    // Whole 128-byte buffer, all slots filled by the bench
    logic [31:0] mem [0:31];
    int slow = 0;
    int wait_cnt = 0;
    initial begin
        rd_ack = 1'b0;
        rd_data = 32'h0000_0000;
    end
    always @(posedge clk) begin
        rd_ack <= 1'b0;
        // Data lines never keep the last word
        rd_data <= ~rd_data;
        if (rd_req && !rd_ack) begin
            if (wait_cnt < slow) begin
                wait_cnt <= wait_cnt + 1;
            end else begin
                wait_cnt <= 0;
                rd_ack <= 1'b1;
                rd_data <= mem[rd_addr[6:2]];
            end
        end
    end
endmodule
`default_nettype wire

// >>> sim/tb_setup_frame_address_filter.sv
// Self-checking bench of the setup filter
`timescale 1ns/1ps
`default_nettype none
`include "sff_regs.svh"
module tb_setup_frame_address_filter;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic reg_wr = 1'b0, reg_rd = 1'b0, setup_req = 1'b0, tx_running = 1'b1, rx_busy = 1'b0;
    logic da_valid = 1'b0, irq, setup_busy, rx_detach, dma_rd_req, dma_rd_ack;
    logic desc_wr_valid, filt_valid, filt_accept;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0000_0000, w1 = 32'h0000_0000, w2 = 32'h0000_0000;
    logic [31:0] reg_rdata, dma_rd_addr, dma_rd_data, cfg_desc_word0, w0, r;
    logic [47:0] da = 48'h0000_0000_0000;
    logic [8:0] hi;
    logic tx_quiet = 1'b1;
    int err_count = 0;
    int checked = 0;
    always #2.5 clk = ~clk;
    sff_filter dut (.clk, .reset, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .irq,
        .setup_req, .cfg_desc_word1(w1), .cfg_desc_word2(w2), .cfg_desc_word3(32'h0000_0100),
        .tx_running, .tx_quiet, .rx_busy, .setup_busy, .rx_detach, .dma_rd_req,
        .dma_rd_addr, .dma_rd_ack, .dma_rd_data, .desc_wr_valid, .cfg_desc_word0, .da_valid,
        .da, .filt_valid, .filt_accept);
    sff_host_mem host (.clk, .rd_req(dma_rd_req), .rd_addr(dma_rd_addr), .rd_ack(dma_rd_ack),
        .rd_data(dma_rd_data));
    task automatic chk(input string name, input logic [47:0] exp, input logic [47:0] got);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic reg_read(input logic [7:0] a);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 r = reg_rdata;
    endtask
    task automatic filt(input logic [47:0] a, input logic exp);
        @(posedge clk);
        da <= a;
        da_valid <= 1'b1;
        @(posedge clk);
        da_valid <= 1'b0;
        #1;
        chk("filt_valid", 48'h1, {47'h0, filt_valid});
        chk("filt_accept", {47'h0, exp}, {47'h0, filt_accept});
    endtask
    task automatic load(input logic [31:0] d1, input logic [14:0] len);
        logic det;
        logic bad;
        det = 1'b0;
        bad = (len != `SFF_SETUP_BYTES);
        @(posedge clk);
        w1 <= d1 | 32'h2000_0000;
        w2 <= {1'b0, len, 16'h0000};
        setup_req <= 1'b1;
        @(posedge clk);
        setup_req <= 1'b0;
        #1 chk("busy", 48'h1, {47'h0, setup_busy});
        for (int n = 0; n < 400 && desc_wr_valid !== 1'b1; n++) begin
            @(posedge clk);
            #1 det = det | rx_detach;
        end
        w0 = cfg_desc_word0;
        chk("wrback", 48'h1, {47'h0, desc_wr_valid});
        chk("detach", 48'h1, {47'h0, det});
        chk("holder", 48'h0, {47'h0, w0[31]});
        chk("bad_len", {47'h0, bad}, {47'h0, w0[13]});
        chk("err_sum", {47'h0, bad}, {47'h0, w0[15]});
    endtask
    function automatic logic [8:0] crc9(input logic [47:0] a);
        logic [31:0] c;
        c = `SFF_CRC_INIT;
        for (int k = 0; k < 48; k++) begin
            c = (c[0] ^ a[k]) ? ((c >> 1) ^ `SFF_CRC_POLY) : (c >> 1);
        end
        return c[8:0];
    endfunction
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    initial begin
        #100000;
        err_count++;
        give_verdict();
    end
    initial begin
        repeat (4) @(posedge clk);
        reset <= 1'b0;
        filt(48'h0, 1'b1);
        filt(48'h0000_0000_0100, 1'b0);
        for (int i = 0; i < 16; i++) begin
            host.mem[2 * i] = 32'h1265_09A8;
            host.mem[2 * i + 1] = 32'h0000_7634;
        end
        load(32'h0100_0000, `SFF_SETUP_BYTES);
        filt(48'h7634_1265_09A8, 1'b1);
        filt(48'h7634_1265_08A8, 1'b0);
        chk("irq_off", 48'h0, {47'h0, irq});
        reg_read(`SFF_STATUS_OFS);
        chk("tx_done", 48'h1, {47'h0, r[1]});
        reg_write(`SFF_OPMODE_OFS, 32'h4000_0000);
        repeat (2) @(posedge clk);
        #1 chk("irq_on", 48'h1, {47'h0, irq});
        reg_write(`SFF_STATUS_OFS, 32'h0000_0002);
        repeat (2) @(posedge clk);
        #1 chk("irq_clr", 48'h0, {47'h0, irq});
        reg_read(8'h20);
        chk("unmapped", 48'h0, {16'h0, r});
        host.slow = 3;
        fork
            load(32'h0400_0000, `SFF_SETUP_BYTES);
            begin
                repeat (10) @(posedge clk);
                da <= 48'h7634_1265_09A8;
                da_valid <= 1'b1;
                @(posedge clk);
                da_valid <= 1'b0;
                #1 chk("filt_drop", 48'h0, {47'h0, filt_valid});
            end
        join
        filt(48'h7634_1265_09A8, 1'b0);
        filt(48'h7634_1265_08A8, 1'b1);
        @(posedge clk);
        rx_busy <= 1'b1;
        tx_quiet <= 1'b0;
        tx_running <= 1'b0;
        fork
            load(32'h0000_0000, 15'h0040);
            begin
                repeat (20) @(posedge clk);
                #1 chk("gate", 48'h0, {47'h0, rx_detach});
                @(posedge clk);
                tx_running <= 1'b1;
                repeat (8) @(posedge clk);
                #1 chk("gate_quiet", 48'h0, {47'h0, rx_detach});
                @(posedge clk);
                tx_quiet <= 1'b1;
                repeat (8) @(posedge clk);
                #1 chk("gate_rx", 48'h0, {47'h0, rx_detach});
                @(posedge clk);
                rx_busy <= 1'b0;
            end
        join
        filt(48'h7634_1265_09A8, 1'b0);
        host.slow = 0;
        for (int i = 0; i < 18; i++) begin
            host.mem[i] = 32'h0000_0000;
        end
        // Hash table for seven multicast groups
        host.mem[1] = 32'h1000_0000;
        host.mem[5] = 32'h4000_0000;
        host.mem[6] = 32'h0000_0080;
        host.mem[7] = 32'h0010_0000;
        host.mem[9] = 32'h1000_0000;
        host.mem[13] = 32'h0001_0000;
        host.mem[15] = 32'h0040_0000;
        host.mem[16] = 32'h3534_12A8;
        host.mem[17] = 32'h0000_0876;
        load(32'h0200_0000, `SFF_SETUP_BYTES);
        filt(48'h0027_0025_0025, 1'b1);
        filt(48'h8725_3F62_C5A3, 1'b1);
        filt(48'h820B_99C0_C2D9, 1'b1);
        filt(48'h0ACC_FD4D_487D, 1'b1);
        filt(48'hDD89_3696_C1E7, 1'b1);
        filt(48'hC7D3_5528_CC61, 1'b1);
        filt(48'h7E2D_550A_466B, 1'b1);
        hi = crc9(48'h0087_253F_62A3);
        filt(48'h0087_253F_62A3, host.mem[hi[8:5]][hi[4:0]]);
        filt(48'h0876_3534_12A8, 1'b1);
        filt(48'h0876_3534_13A8, 1'b0);
        reg_write(`SFF_OPMODE_OFS, 32'h4000_0002);
        filt(48'h0876_3534_13A8, 1'b1);
        reg_write(`SFF_OPMODE_OFS, 32'h4000_0004);
        filt(48'h0087_253F_62A3, 1'b1);
        filt(48'h0876_3534_13A8, 1'b0);
        give_verdict();
    end
endmodule
`default_nettype wire
